// File: logic/vfs_pkg.sv
/*
 Constants for the vector file store and its instruction receive front end:
 sizes, element address fields, control word fields, register map.
 Assumes a single clock domain; no other file is needed.
*/
`default_nettype none
package vfs_pkg;
   localparam int NUM_BLK    = 8;
   localparam int NUM_PIPE   = 5;
   localparam int PAIR_W     = 72;
   localparam int WORD_W     = 36;
   localparam int IDX_W      = 8;
   localparam int ENTRIES    = 256;
   localparam int ADDR_W     = 12;
   localparam int CW_W       = 50;
   localparam int CNT_W      = 7;
   localparam int PTR_W      = 6;
   localparam int RMX_W      = 5;
   // Element address fields
   localparam int EA_IDX_LSB = 0;
   localparam int EA_BASE_W  = 6;
   localparam int EA_BLK_LSB = 8;
   localparam int EA_EO      = 11;
   // Control word fields
   localparam int CW_PIPE_LSB = 0;
   localparam int CW_DUAL     = 3;
   localparam int CW_PIPE2_LSB = 4;
   localparam logic [2:0] PIPE_SCALAR = 3'h4;
   localparam logic [2:0] PIPE_LAST   = 3'h4;
   // Write sources
   localparam logic [1:0] SRC_SCALAR = 2'h0;
   localparam logic [1:0] SRC_LOAD   = 2'h1;
   localparam logic [1:0] SRC_PIPE   = 2'h2;
   // Register map
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ACKCNT = 8'h08;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} vfs_state_e;
endpackage
`default_nettype wire

// File: logic/vfs_top.sv
/*
 Vector file store with element addressing, per-pipeline read multiplexer
 counters and the instruction receive and acknowledge front end.
 Assumes one clock, synchronous active-low reset, AXI4-Lite register access,
 and a scalar side that holds its word until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module vfs_top
   import vfs_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                ctl_valid,
   input  wire logic [CW_W-1:0]     ctl_word,
   input  wire logic [CNT_W-1:0]    elem_count,
   input  wire logic [PTR_W-1:0]    elem_ptr,
   input  wire logic                elem_count_zero,
   input  wire logic                range_abort,
   output logic                     ctl_ack,
   output logic [NUM_PIPE-1:0]      pipe_req,
   output logic [CW_W-1:0]          pipe_word,
   output logic [CNT_W-1:0]         pipe_len,
   input  wire logic [NUM_PIPE-1:0] pipe_started,
   input  wire logic                wr_en,
   input  wire logic [1:0]          wr_src,
   input  wire logic                wr_single,
   input  wire logic [ADDR_W-1:0]   wr_addr_a,
   input  wire logic [ADDR_W-1:0]   wr_addr_b,
   input  wire logic [PAIR_W-1:0]   scalar_wdata,
   input  wire logic [PAIR_W-1:0]   load_a_wdata,
   input  wire logic [PAIR_W-1:0]   load_b_wdata,
   input  wire logic [PAIR_W-1:0]   result_wdata,
   input  wire logic [2:0]          rd_pipe_pri,
   input  wire logic [EA_BASE_W-1:0] rd_base_pri,
   input  wire logic [2:0]          rd_pipe_sec,
   input  wire logic [EA_BASE_W-1:0] rd_base_sec,
   output logic [PAIR_W-1:0]        rd_data_pri,
   output logic [PAIR_W-1:0]        rd_data_sec
);

   function automatic logic [NUM_PIPE-1:0] pipe_onehot(input logic [2:0] p);
      pipe_onehot = '0;
      if (p <= PIPE_LAST)
      begin
         pipe_onehot[p] = 1'b1;
      end
   endfunction

   // Element address for one pipe sweep: base holds bits 0-5
   function automatic logic [ADDR_W-1:0] sweep_addr(input logic [EA_BASE_W-1:0] base,
                                                    input logic [RMX_W-1:0] cnt);
      sweep_addr = {1'b0, cnt[2:0], cnt[4:3], base};
   endfunction

   // Storage: [block][memory,file,pass]; 2 copies x 8 x 256 x 72 bits
   logic [PAIR_W-1:0]   pri_mem [NUM_BLK][ENTRIES];
   logic [PAIR_W-1:0]   sec_mem [NUM_BLK][ENTRIES];
   logic [RMX_W-1:0]    rmx_cnt_r [NUM_PIPE];
   vfs_state_e          state_r;
   logic [CW_W-1:0]     cw_r;
   logic [CNT_W-1:0]    cnt_r;
   logic [PTR_W-1:0]    ptr_r;
   logic [31:0]         ctrl_r;
   logic [31:0]         ack_cnt_r;
   logic                abort_seen_r;
   logic                aw_hold_r;
   logic                w_hold_r;
   logic [7:0]          awaddr_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic [PAIR_W-1:0]   wdata_a;
   logic [ADDR_W-1:0]   addr_pri;
   logic [ADDR_W-1:0]   addr_sec;
   logic                take;
   logic [2:0]          pipe1;
   logic [2:0]          pipe2;
   logic [CNT_W-1:0]    len_nxt;

   assign pipe1 = ctl_word[CW_PIPE_LSB +: 3];
   assign pipe2 = cw_r[CW_PIPE2_LSB +: 3];
   // Acknowledge cycle is skipped so the held word is not taken twice
   assign take = ctl_valid && (state_r == ST_IDLE) && !ctl_ack && ctrl_r[0];

   // Write source select; load lane A carries the first pair of four words
   always_comb
   begin
      case (wr_src)
         SRC_SCALAR: wdata_a = scalar_wdata;
         SRC_LOAD:   wdata_a = load_a_wdata;
         SRC_PIPE:   wdata_a = result_wdata;
         default:    wdata_a = result_wdata;
      endcase
   end

   // One address drives both copies, keeping them identical
   always_ff @(posedge aclk)
   begin
      if (wr_en)
      begin
         if (!wr_single)
         begin
            pri_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]] <= wdata_a;
            sec_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]] <= wdata_a;
         end
         else if (wr_addr_a[EA_EO])
         begin
            pri_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]][WORD_W-1:0]
               <= wdata_a[WORD_W-1:0];
            sec_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]][WORD_W-1:0]
               <= wdata_a[WORD_W-1:0];
         end
         else
         begin
            pri_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]][PAIR_W-1:WORD_W]
               <= wdata_a[PAIR_W-1:WORD_W];
            sec_mem[wr_addr_a[EA_BLK_LSB +: 3]][wr_addr_a[IDX_W-1:0]][PAIR_W-1:WORD_W]
               <= wdata_a[PAIR_W-1:WORD_W];
         end
         // Second load pair lands in another block the same cycle
         if (wr_src == SRC_LOAD)
         begin
            pri_mem[wr_addr_b[EA_BLK_LSB +: 3]][wr_addr_b[IDX_W-1:0]] <= load_b_wdata;
            sec_mem[wr_addr_b[EA_BLK_LSB +: 3]][wr_addr_b[IDX_W-1:0]] <= load_b_wdata;
         end
      end
   end

   // Read multiplexer counters, one per pipeline
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PIPE; gp++)
      begin : g_rmx
         always_ff @(posedge aclk)
         begin
            if (!aresetn || pipe_started[gp])
            begin
               rmx_cnt_r[gp] <= '0;
            end
            else
            begin
               rmx_cnt_r[gp] <= rmx_cnt_r[gp] + 1'b1;
            end
         end
      end
   endgenerate

   // Independent primary and secondary references from two pipe counters
   assign addr_pri = sweep_addr(rd_base_pri,
      rmx_cnt_r[(rd_pipe_pri <= PIPE_LAST) ? rd_pipe_pri : 3'h0]);
   assign addr_sec = sweep_addr(rd_base_sec,
      rmx_cnt_r[(rd_pipe_sec <= PIPE_LAST) ? rd_pipe_sec : 3'h0]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_data_pri <= '0;
         rd_data_sec <= '0;
      end
      else
      begin
         // Zero address bits 0-7 select entry 0: pass 0, file 0, memory 0
         rd_data_pri <= pri_mem[addr_pri[EA_BLK_LSB +: 3]][addr_pri[IDX_W-1:0]];
         rd_data_sec <= sec_mem[addr_sec[EA_BLK_LSB +: 3]][addr_sec[IDX_W-1:0]];
      end
   end

   // Count to pipes 0-3, pointer to scalar control (pipe 4)
   assign len_nxt = (pipe1 == PIPE_SCALAR) ? CNT_W'(elem_ptr) : elem_count;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r      <= ST_IDLE;
         cw_r         <= '0;
         cnt_r        <= '0;
         ptr_r        <= '0;
         ctl_ack      <= 1'b0;
         pipe_req     <= '0;
         pipe_word    <= '0;
         pipe_len     <= '0;
         abort_seen_r <= 1'b0;
      end
      else
      begin
         ctl_ack <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (take)
               begin
                  cw_r  <= ctl_word;
                  cnt_r <= elem_count;
                  ptr_r <= elem_ptr;
                  // Nothing to execute: acknowledge at once
                  if (range_abort || elem_count_zero || pipe1 > PIPE_LAST)
                  begin
                     ctl_ack      <= 1'b1;
                     abort_seen_r <= range_abort;
                  end
                  else
                  begin
                     pipe_req  <= pipe_onehot(pipe1);
                     pipe_word <= ctl_word;
                     pipe_len  <= len_nxt;
                     state_r   <= ST_FIRST;
                  end
               end
            end
            ST_FIRST:
            begin
               if (|(pipe_started & pipe_req))
               begin
                  if (cw_r[CW_DUAL] && pipe2 <= PIPE_LAST)
                  begin
                     // Second word: second pipe in the select field, dual cleared
                     pipe_req  <= pipe_onehot(pipe2);
                     pipe_word <= {cw_r[CW_W-1:CW_DUAL+1], 1'b0, pipe2};
                     pipe_len  <= (pipe2 == PIPE_SCALAR) ? CNT_W'(ptr_r) : cnt_r;
                     state_r   <= ST_SECOND;
                  end
                  else
                  begin
                     pipe_req <= '0;
                     ctl_ack  <= 1'b1;
                     state_r  <= ST_IDLE;
                  end
               end
            end
            ST_SECOND:
            begin
               if (|(pipe_started & pipe_req))
               begin
                  pipe_req <= '0;
                  ctl_ack  <= 1'b1;
                  state_r  <= ST_IDLE;
               end
            end
            default:
            begin
               state_r  <= ST_IDLE;
               pipe_req <= '0;
            end
         endcase
      end
   end

   // AXI4-Lite write channel: address and data taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         ctrl_r        <= CTRL_RST;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_hold_r && !s_axi_awready && !s_axi_bvalid)
         begin
            aw_hold_r     <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && !w_hold_r && !s_axi_wready && !s_axi_bvalid)
         begin
            w_hold_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
         if (aw_hold_r && w_hold_r && !s_axi_bvalid)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == OFF_CTRL)
            begin
               s_axi_bresp <= RESP_OKAY;
               if (wstrb_r[0])
               begin
                  ctrl_r[0] <= wdata_r[0];
               end
            end
            else if (awaddr_r == OFF_STATUS || awaddr_r == OFF_ACKCNT)
            begin
               s_axi_bresp <= RESP_OKAY;
            end
            else
            begin
               s_axi_bresp <= RESP_SLV;
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel: answer in the same cycle as the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
               OFF_CTRL:   s_axi_rdata <= {31'h0, ctrl_r[0]};
               OFF_STATUS: s_axi_rdata <= {24'h0, 3'h0, pipe_req != '0, abort_seen_r,
                                           1'b0, state_r};
               OFF_ACKCNT: s_axi_rdata <= ack_cnt_r;
               default:
               begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLV;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ack_cnt_r <= '0;
      end
      else if (ctl_ack)
      begin
         ack_cnt_r <= ack_cnt_r + 32'h0000_0001;
      end
   end

   // Checks
   sequence s_first_start;
      state_r == ST_FIRST && |(pipe_started & pipe_req);
   endsequence

   sequence s_dual_first;
      s_first_start ##0 cw_r[CW_DUAL] && pipe2 <= PIPE_LAST;
   endsequence

   property p_rmx_restart;
      @(posedge aclk) disable iff (!aresetn)
      pipe_started[0] |=> rmx_cnt_r[0] == '0;
   endproperty
   a_rmx_restart: assert property (p_rmx_restart) else $error("counter not restarted");

   property p_rmx_advance;
      @(posedge aclk) disable iff (!aresetn)
      !pipe_started[1] |=> rmx_cnt_r[1] == RMX_W'($past(rmx_cnt_r[1]) + 1'b1);
   endproperty
   a_rmx_advance: assert property (p_rmx_advance) else $error("counter did not advance");

   property p_pass_wrap;
      @(posedge aclk) disable iff (!aresetn)
      (rmx_cnt_r[2] == 5'h1f && !pipe_started[2]) |=> rmx_cnt_r[2] == 5'h00;
   endproperty
   a_pass_wrap: assert property (p_pass_wrap) else $error("pass did not wrap");

   property p_single_ack;
      @(posedge aclk) disable iff (!aresetn)
      (s_first_start ##0 !cw_r[CW_DUAL]) |=> ctl_ack && state_r == ST_IDLE;
   endproperty
   a_single_ack: assert property (p_single_ack) else $error("missing acknowledge");

   property p_dual_hold;
      @(posedge aclk) disable iff (!aresetn)
      s_dual_first |=> !ctl_ack && state_r == ST_SECOND && pipe_req == pipe_onehot(pipe2);
   endproperty
   a_dual_hold: assert property (p_dual_hold) else $error("dual acknowledge early");

   property p_len_fwd;
      @(posedge aclk) disable iff (!aresetn)
      (take && !range_abort && !elem_count_zero && pipe1 < PIPE_SCALAR)
         |=> pipe_len == $past(elem_count) && pipe_word == $past(ctl_word);
   endproperty
   a_len_fwd: assert property (p_len_fwd) else $error("count not forwarded");

   property p_abort_ack;
      @(posedge aclk) disable iff (!aresetn)
      (take && range_abort) |=> ctl_ack ##1 !ctl_ack && state_r == ST_IDLE;
   endproperty
   a_abort_ack: assert property (p_abort_ack) else $error("abort not acknowledged");

   property p_dup_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_en && !wr_single && wr_src != SRC_LOAD)
         |=> pri_mem[$past(wr_addr_a[EA_BLK_LSB +: 3])][$past(wr_addr_a[IDX_W-1:0])]
             == sec_mem[$past(wr_addr_a[EA_BLK_LSB +: 3])][$past(wr_addr_a[IDX_W-1:0])];
   endproperty
   a_dup_write: assert property (p_dup_write) else $error("copies differ after write");

endmodule
`default_nettype wire

// File: tb/vfs_scalar_model.sv
/*
 Scalar side model: on a go request presents one control word with its loop
 parameters and holds them until the block acknowledges.
 Assumes ctl_ack is a one-cycle pulse and a single rising-edge clock.
*/
`timescale 1ns/1ps
`default_nettype none
module vfs_scalar_model
   import vfs_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             go,
   input  wire logic [CW_W-1:0]  go_word,
   input  wire logic             go_zero,
   input  wire logic             go_abort,
   input  wire logic [CNT_W-1:0] go_count,
   input  wire logic [PTR_W-1:0] go_ptr,
   input  wire logic             ctl_ack,
   output logic                  ctl_valid,
   output logic [CW_W-1:0]       ctl_word,
   output logic [CNT_W-1:0]      elem_count,
   output logic [PTR_W-1:0]      elem_ptr,
   output logic                  elem_count_zero,
   output logic                  range_abort,
   output logic                  done
);
   always_ff @(posedge aclk)
   begin
      done <= 1'h0;
      if (!aresetn)
      begin
         ctl_valid       <= 1'h0;
         ctl_word        <= '0;
         elem_count      <= '0;
         elem_ptr        <= '0;
         elem_count_zero <= 1'h0;
         range_abort     <= 1'h0;
      end
      else if (ctl_valid && ctl_ack)
      begin
         // Inverted after release so a stale word can never pass for a held one
         ctl_valid       <= 1'h0;
         ctl_word        <= ~ctl_word;
         elem_count      <= ~elem_count;
         elem_ptr        <= ~elem_ptr;
         elem_count_zero <= ~elem_count_zero;
         range_abort     <= ~range_abort;
         done            <= 1'h1;
      end
      else if (!ctl_valid && go)
      begin
         ctl_valid       <= 1'h1;
         ctl_word        <= go_word;
         elem_count      <= go_count;
         elem_ptr        <= go_ptr;
         elem_count_zero <= go_zero;
         range_abort     <= go_abort;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 Testbench for the vector file store: register access, instruction issue and
 acknowledge, and write then read-back through the pipe read counters.
 Assumes vfs_top, the scalar side model and one 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vfs_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ctl_valid, elem_count_zero, range_abort, ctl_ack, done;
   logic [CW_W-1:0] ctl_word, pipe_word, go_word = '0;
   logic [CNT_W-1:0] elem_count, pipe_len, go_count = 7'h2a;
   logic [PTR_W-1:0] elem_ptr, go_ptr = 6'h15;
   logic [NUM_PIPE-1:0] pipe_req, pipe_started = '0;
   logic go = 1'h0, go_zero = 1'h0, go_abort = 1'h0, wr_en = 1'h0, wr_single = 1'h0;
   logic [1:0] wr_src = '0;
   logic [ADDR_W-1:0] wr_addr_a = '0, wr_addr_b = '0;
   logic [PAIR_W-1:0] scalar_wdata = '0, load_a_wdata = '0, load_b_wdata = '0;
   logic [PAIR_W-1:0] result_wdata = '0, rd_data_pri, rd_data_sec;
   logic [2:0] rd_pipe_pri = '0, rd_pipe_sec = '0;
   logic [EA_BASE_W-1:0] rd_base_pri = '0, rd_base_sec = '0;
   int err_total = 0, n_checks = 0, cyc = 0, acks = 0;

   vfs_top vfs_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ctl_valid, .ctl_word, .elem_count, .elem_ptr,
      .elem_count_zero, .range_abort, .ctl_ack, .pipe_req, .pipe_word, .pipe_len, .pipe_started,
      .wr_en, .wr_src, .wr_single, .wr_addr_a, .wr_addr_b, .scalar_wdata, .load_a_wdata,
      .load_b_wdata, .result_wdata, .rd_pipe_pri, .rd_base_pri, .rd_pipe_sec, .rd_base_sec,
      .rd_data_pri, .rd_data_sec);
   vfs_scalar_model vfs_scalar_model_inst (.aclk, .aresetn, .go, .go_word, .go_zero, .go_abort,
      .go_count, .go_ptr, .ctl_ack, .ctl_valid, .ctl_word, .elem_count, .elem_ptr,
      .elem_count_zero, .range_abort, .done);

   always #2.5 aclk = ~aclk;

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Generous ceiling: the whole sequence needs under two hundred cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (ctl_ack === 1'h1)
         acks <= acks + 1;
      if (cyc == 4000)
      begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [PAIR_W-1:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      // One idle edge so a following call never re-drives a signal in this step
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask

   task automatic pulse(input logic [2:0] p);
      pipe_started <= NUM_PIPE'(1) << p;
      @(posedge aclk);
      pipe_started <= '0;
   endtask

   task automatic wait_req(input logic [2:0] p);
      do
         @(posedge aclk);
      while (pipe_req !== NUM_PIPE'(NUM_PIPE'(1) << p));
   endtask

   // skip[0] count zero, skip[1] range abort: acknowledged with no pipe start
   task automatic instr(input logic [2:0] p1, input logic dual, input logic [2:0] p2,
                        input logic [1:0] skip);
      logic [CW_W-1:0] w;
      int a0;
      w = {40'h12_3456_789a, 3'h0, p2, dual, p1};
      a0 = acks;
      go_word  <= w;
      go_zero  <= skip[0];
      go_abort <= skip[1];
      go       <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      if (skip == 2'h0)
      begin
         wait_req(p1);
         chk("pipe_word", w, pipe_word);
         chk("pipe_len", (p1 == PIPE_SCALAR) ? CNT_W'(go_ptr) : go_count, pipe_len);
         pulse(p1);
         if (dual)
         begin
            wait_req(p2);
            chk("early ack", a0, acks);
            chk("second word", {w[49:4], 1'h0, p2}, pipe_word);
            pulse(p2);
         end
      end
      do
      begin
         @(posedge aclk);
         if (skip != 2'h0)
            chk("no issue", 0, pipe_req);
      end
      while (done !== 1'h1);
      chk("ack count", a0 + 1, acks);
   endtask

   task automatic wr(input logic [1:0] src, input logic [11:0] a, b);
      wr_en     <= 1'h1;
      wr_src    <= src;
      wr_addr_a <= a;
      wr_addr_b <= b;
      @(posedge aclk);
   endtask

   task automatic store_sweep();
      logic [7:0] pats [4];
      pats = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
      rd_base_pri  <= 6'h25;
      load_a_wdata <= {9{8'ha1}};
      load_b_wdata <= {9{8'hb2}};
      wr(SRC_LOAD, {4'h3, 2'h1, 6'h25}, {4'h4, 2'h1, 6'h25});
      result_wdata <= {9{8'hc3}};
      wr(SRC_PIPE, {4'h5, 2'h1, 6'h25}, 12'h000);
      scalar_wdata <= {9{8'hd4}};
      wr(SRC_SCALAR, {4'h6, 2'h1, 6'h25}, 12'h000);
      result_wdata <= {9{8'he5}};
      wr(SRC_PIPE, 12'h000, 12'h000);
      wr_en <= 1'h0;
      pulse(3'h0);
      // Counter 0 restarts at the pulse edge; read data trails the count by one edge
      repeat (2) @(posedge aclk);
      chk("zero address", {9{8'he5}}, rd_data_sec);
      repeat (10) @(posedge aclk);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge aclk);
         chk("block sweep", {9{pats[i]}}, rd_data_pri);
      end
      rd_base_pri <= 6'h00;
      rd_base_sec <= 6'h25;
      repeat (18) @(posedge aclk);
      chk("second lap pri", {9{8'he5}}, rd_data_pri);
      repeat (11) @(posedge aclk);
      chk("second lap sec", {9{8'ha1}}, rd_data_sec);
      wr_single    <= 1'h1;
      scalar_wdata <= {9{8'hf6}};
      wr(SRC_SCALAR, {4'he, 2'h1, 6'h25}, 12'h000);
      wr_en     <= 1'h0;
      wr_single <= 1'h0;
      pulse(3'h0);
      repeat (16) @(posedge aclk);
      chk("odd single write", 72'hd4_d4d4_d4d6_f6f6_f6f6, rd_data_sec);
   endtask

   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axi_rd(OFF_CTRL, d, r);
      chk("ctrl reset", CTRL_RST, d);
      axi_rd(8'h0c, d, r);
      chk("unmapped read", RESP_SLV, r);
      axi_wr(8'h10, 32'h0000_0000, r);
      chk("unmapped write", RESP_SLV, r);
      axi_wr(OFF_CTRL, 32'h0000_0000, r);
      chk("ctrl write resp", RESP_OKAY, r);
      axi_rd(OFF_CTRL, d, r);
      chk("ctrl cleared", 32'h0000_0000, d);
      axi_wr(OFF_CTRL, 32'h0000_0001, r);
      instr(3'h0, 1'h0, 3'h0, 2'h0);
      instr(3'h4, 1'h0, 3'h0, 2'h0);
      instr(3'h1, 1'h1, 3'h2, 2'h0);
      instr(3'h3, 1'h0, 3'h0, 2'h1);
      instr(3'h2, 1'h0, 3'h0, 2'h2);
      axi_rd(OFF_STATUS, d, r);
      chk("status", 32'h0000_0008, d);
      chk("status resp", RESP_OKAY, r);
      axi_rd(OFF_ACKCNT, d, r);
      chk("ack counter", 5, d);
      store_sweep();
      close_out();
   end
endmodule
`default_nettype wire
